// *** inc/gain_sched_params.svh ***
// Notes on behaviour
// - nonzero tuning mode makes the block derive control parameters from stiffness.
// - while the tuning mode is nonzero, a valid load estimate updates the stored inertia ratio.
// - in compensating modes, friction and torque compensation values take estimates.
// - every 30 minutes, while the tuning mode is nonzero, the tuning results are written to nonvolatile memory.
// - after power-up tuning starts from the values restored from nonvolatile memory.
// - gain-set updates, stiffness included, are applied only while the motor is stopped.
// - tuning in two-degree-of-freedom mode forces torque feed-forward to zero.
// - both gain sets load from a stiffness table, rows 0 to 17.
// - time constant column is standard or high-response per tuning mode.
`ifndef GAIN_SCHED_PARAMS_SVH
`define GAIN_SCHED_PARAMS_SVH
`define SAVE_PERIOD_MIN 30
`define CLK_HZ 64'h0000000002625A00
`define SAVE_PERIOD_CYCLES (`SAVE_PERIOD_MIN * 60 * `CLK_HZ)
`define STIFF_MAX 17
`define MODE_OFF 4'h0
`define MODE_HIGH_FIRST 4'h2
`define MODE_HIGH_LAST 4'h4
`define MODE_COMP_FIRST 4'h5
`define FF_GAIN_DEFAULT 16'h03E8
`endif

// *** inc/gain_sched_pkg.sv ***
package gain_sched_pkg;
  typedef struct packed {
    logic [15:0] pos_gain;
    logic [15:0] spd_gain;
    logic [15:0] integ;
    logic [15:0] tq_filt;
    logic [15:0] cmd_std;
    logic [15:0] cmd_high;
    logic [15:0] tune_filt;
    logic [15:0] load_filt;
  } gain_row_t;
  typedef struct packed {
    logic [15:0] inertia;
    logic [15:0] tq_add;
    logic [15:0] pos_comp;
    logic [15:0] neg_comp;
    logic [15:0] visc;
  } tune_result_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_WAIT = 2'b11
  } save_state_t;
endpackage : gain_sched_pkg

// *** inc/gain_row_if.sv ***
`timescale 1ns/1ps
interface gain_row_if;
  logic [4:0] index;
  gain_sched_pkg::gain_row_t row;
  modport user (output index, input row);
  modport table_side (input index, output row);
endinterface : gain_row_if

// *** verilog/gain_table.sv ***
`timescale 1ns/1ps
module gain_table (
  gain_row_if.table_side tbl
);
  // ----------------------------------------
  // stiffness rows, 8 fields of 16 bits
  // ----------------------------------------
  function automatic gain_sched_pkg::gain_row_t row_of(input logic [4:0] s);
    unique case (s)
      5'h00: row_of = {16'h0014, 16'h000F, 16'h0E74, 16'h05DC, 16'h077F, 16'h02FC, 16'h009B, 16'h09C4};
      5'h01: row_of = {16'h0019, 16'h0014, 16'h0AF0, 16'h044C, 16'h05CF, 16'h0253, 16'h0073, 16'h09C4};
      5'h02: row_of = {16'h001E, 16'h0019, 16'h0898, 16'h0384, 16'h04BE, 16'h01E6, 16'h005E, 16'h09C4};
      5'h03: row_of = {16'h0028, 16'h001E, 16'h076C, 16'h0320, 16'h03C0, 16'h0180, 16'h0054, 16'h09C4};
      5'h04: row_of = {16'h002D, 16'h0023, 16'h0640, 16'h0258, 16'h0346, 16'h014F, 16'h0040, 16'h09C4};
      5'h05: row_of = {16'h0037, 16'h002D, 16'h04B0, 16'h01F4, 16'h029C, 16'h010B, 16'h0036, 16'h09C4};
      5'h06: row_of = {16'h004B, 16'h003C, 16'h0384, 16'h0190, 16'h01F0, 16'h00C6, 16'h002C, 16'h09C4};
      5'h07: row_of = {16'h005F, 16'h004B, 16'h02BC, 16'h012C, 16'h018A, 16'h009E, 16'h0022, 16'h0848};
      5'h08: row_of = {16'h0073, 16'h005A, 16'h0258, 16'h012C, 16'h0147, 16'h0083, 16'h0022, 16'h06EA};
      5'h09: row_of = {16'h008C, 16'h006E, 16'h01F4, 16'h00C8, 16'h010C, 16'h006B, 16'h0018, 16'h05AA};
      5'h0A: row_of = {16'h00AF, 16'h008C, 16'h0190, 16'h00C8, 16'h00D4, 16'h0055, 16'h0017, 16'h0474};
      5'h0B: row_of = {16'h0140, 16'h00B4, 16'h0136, 16'h007E, 16'h008B, 16'h0037, 16'h0010, 16'h0370};
      5'h0C: row_of = {16'h0186, 16'h00DC, 16'h00FA, 16'h0067, 16'h0071, 16'h002D, 16'h000D, 16'h02D0};
      5'h0D: row_of = {16'h01E0, 16'h010E, 16'h00D2, 16'h0054, 16'h005C, 16'h0025, 16'h000B, 16'h024E};
      5'h0E: row_of = {16'h0276, 16'h015E, 16'h00A0, 16'h0041, 16'h0047, 16'h001C, 16'h0009, 16'h01C2};
      5'h0F: row_of = {16'h02D0, 16'h0190, 16'h008C, 16'h0039, 16'h003E, 16'h0019, 16'h0008, 16'h0190};
      5'h10: row_of = {16'h0384, 16'h01F4, 16'h0078, 16'h002D, 16'h0032, 16'h0014, 16'h0007, 16'h0140};
      5'h11: row_of = {16'h0438, 16'h0258, 16'h006E, 16'h0026, 16'h0029, 16'h0011, 16'h0006, 16'h010E};
      default: row_of = {16'h0438, 16'h0258, 16'h006E, 16'h0026, 16'h0029, 16'h0011, 16'h0006, 16'h010E};
    endcase
  endfunction : row_of

  assign tbl.row = row_of(tbl.index);
endmodule : gain_table

// *** verilog/realtime_autotune_gain_scheduler.sv ***
`timescale 1ns/1ps
`include "gain_sched_params.svh"
module realtime_autotune_gain_scheduler #(
  parameter longint SAVE_CYCLES = `SAVE_PERIOD_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] tuning_mode_select,
  input wire logic [4:0] stiffness_setting,
  input wire logic two_dof_mode,
  input wire logic motor_moving_pin,
  input wire logic operation_start,
  input wire logic estimate_valid,
  input wire gain_sched_pkg::tune_result_t estimate,
  input wire gain_sched_pkg::tune_result_t restored,
  input wire logic restore_valid,
  input wire logic [15:0] torque_feedforward_gain,
  input wire logic nvm_ready,
  output logic [15:0] position_gain_set1,
  output logic [15:0] position_gain_set2,
  output logic [15:0] speed_gain_set1,
  output logic [15:0] speed_gain_set2,
  output logic [15:0] integral_time_set1,
  output logic [15:0] integral_time_set2,
  output logic [15:0] torque_filter_set1,
  output logic [15:0] torque_filter_set2,
  output logic [15:0] command_smoothing_time,
  output logic [15:0] tuning_filter_time,
  output logic [15:0] load_fluctuation_filter,
  output logic [15:0] inertia_ratio,
  output logic [15:0] torque_addition_value,
  output logic [15:0] pos_direction_compensation,
  output logic [15:0] neg_direction_compensation,
  output logic [15:0] viscous_friction_gain,
  output logic [15:0] effective_ff_gain,
  output logic [4:0] applied_stiffness,
  output logic stiffness_pending,
  output logic nvm_write,
  output gain_sched_pkg::tune_result_t nvm_data
);
  initial begin
    if (SAVE_CYCLES < 2) $error("SAVE_CYCLES too small");
  end

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic moving_meta;
  logic moving;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      moving_meta <= 1'b0;
      moving <= 1'b0;
    end else if (clk_en) begin
      moving_meta <= motor_moving_pin;
      moving <= moving_meta;
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire tuning_on = tuning_mode_select != `MODE_OFF;
  wire high_resp = tuning_mode_select >= `MODE_HIGH_FIRST
    && tuning_mode_select <= `MODE_HIGH_LAST;
  wire comp_mode = tuning_mode_select >= `MODE_COMP_FIRST;
  wire [4:0] clamped_stiff = (stiffness_setting > 5'(`STIFF_MAX)) ?
    5'(`STIFF_MAX) : stiffness_setting;
  // stopped motor is the only window for gain changes
  wire apply_now = tuning_on && !moving && stiffness_pending;

  gain_row_if row_bus ();
  assign row_bus.index = clamped_stiff;
  gain_table u_table (.tbl(row_bus));
  wire gain_sched_pkg::gain_row_t row = row_bus.row;
  wire [15:0] next_cmd_time = high_resp ? row.cmd_high : row.cmd_std;

  // ----------------------------------------
  // pending stiffness and row apply
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stiffness_pending <= 1'b1;
      applied_stiffness <= 5'h00;
    end else if (clk_en) begin
      if (apply_now)
        applied_stiffness <= clamped_stiff;
      // a change landing in the apply cycle is caught by the compare one cycle later
      stiffness_pending <= !apply_now
        && (stiffness_pending || clamped_stiff != applied_stiffness);
    end
  end

  // whole row lands in one cycle, never a partial update
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      position_gain_set1 <= 16'h0000;
      position_gain_set2 <= 16'h0000;
      speed_gain_set1 <= 16'h0000;
      speed_gain_set2 <= 16'h0000;
      integral_time_set1 <= 16'h0000;
      integral_time_set2 <= 16'h0000;
      torque_filter_set1 <= 16'h0000;
      torque_filter_set2 <= 16'h0000;
      command_smoothing_time <= 16'h0000;
      tuning_filter_time <= 16'h0000;
      load_fluctuation_filter <= 16'h0000;
    end else if (clk_en && apply_now) begin
      position_gain_set1 <= row.pos_gain;
      position_gain_set2 <= row.pos_gain;
      speed_gain_set1 <= row.spd_gain;
      speed_gain_set2 <= row.spd_gain;
      integral_time_set1 <= row.integ;
      integral_time_set2 <= row.integ;
      torque_filter_set1 <= row.tq_filt;
      torque_filter_set2 <= row.tq_filt;
      command_smoothing_time <= next_cmd_time;
      tuning_filter_time <= row.tune_filt;
      load_fluctuation_filter <= row.load_filt;
    end
  end

  // ----------------------------------------
  // tuning results
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      inertia_ratio <= 16'h0000;
      torque_addition_value <= 16'h0000;
      pos_direction_compensation <= 16'h0000;
      neg_direction_compensation <= 16'h0000;
      viscous_friction_gain <= 16'h0000;
    end else if (clk_en) begin
      if (restore_valid) begin
        inertia_ratio <= restored.inertia;
        torque_addition_value <= restored.tq_add;
        pos_direction_compensation <= restored.pos_comp;
        neg_direction_compensation <= restored.neg_comp;
        viscous_friction_gain <= restored.visc;
      end else if (tuning_on && estimate_valid) begin
        inertia_ratio <= estimate.inertia;
        if (comp_mode) begin
          torque_addition_value <= estimate.tq_add;
          pos_direction_compensation <= estimate.pos_comp;
          neg_direction_compensation <= estimate.neg_comp;
          viscous_friction_gain <= estimate.visc;
        end
      end
    end
  end

  // ----------------------------------------
  // feed-forward override
  // ----------------------------------------
  logic ff_forced;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ff_forced <= 1'b0;
      effective_ff_gain <= 16'h0000;
    end else if (clk_en) begin
      // held until the next operation once tuning is left
      if (tuning_on && two_dof_mode)
        ff_forced <= 1'b1;
      else if (operation_start)
        ff_forced <= 1'b0;
      effective_ff_gain <= (ff_forced || (tuning_on && two_dof_mode)) ?
        16'h0000 : torque_feedforward_gain;
    end
  end

  // ----------------------------------------
  // periodic save
  // ----------------------------------------
  gain_sched_pkg::save_state_t state;
  logic [63:0] save_count;
  wire save_due = save_count >= 64'(SAVE_CYCLES - 1);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= gain_sched_pkg::ST_IDLE;
      save_count <= 64'h0000000000000000;
      nvm_write <= 1'b0;
      nvm_data <= '0;
    end else if (clk_en) begin
      unique case (state)
        gain_sched_pkg::ST_IDLE: begin
          save_count <= save_due ? 64'h0 : save_count + 64'h1;
          if (save_due && tuning_on) begin
            state <= gain_sched_pkg::ST_WRITE;
            nvm_data <= {inertia_ratio, torque_addition_value,
              pos_direction_compensation, neg_direction_compensation, viscous_friction_gain};
          end
        end
        gain_sched_pkg::ST_WRITE: begin
          nvm_write <= 1'b1;
          state <= gain_sched_pkg::ST_WAIT;
        end
        gain_sched_pkg::ST_WAIT: begin
          nvm_write <= 1'b0;
          save_count <= save_count + 64'h1;
          if (nvm_ready)
            state <= gain_sched_pkg::ST_IDLE;
        end
        default: state <= gain_sched_pkg::ST_IDLE;
      endcase
    end
  end
endmodule : realtime_autotune_gain_scheduler

// *** verification/gain_sched_chk.sv ***
`timescale 1ns/1ps
module gain_sched_chk #(
  parameter longint SAVE_CYCLES = 100
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] tuning_mode_select,
  input wire logic two_dof_mode,
  input wire logic motor_moving_pin,
  input wire logic estimate_valid,
  input wire gain_sched_pkg::tune_result_t estimate,
  input wire gain_sched_pkg::tune_result_t restored,
  input wire logic restore_valid,
  input wire logic [15:0] position_gain_set1,
  input wire logic [15:0] position_gain_set2,
  input wire logic [15:0] speed_gain_set1,
  input wire logic [15:0] speed_gain_set2,
  input wire logic [15:0] inertia_ratio,
  input wire logic [15:0] effective_ff_gain,
  input wire logic nvm_write
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence moving_s;
    motor_moving_pin [*4];
  endsequence
  a_stop_gate: assert property (moving_s ##1 1'b1 |-> $stable(position_gain_set1) || $past(rst))
    else $error("gain changed while moving");
  a_mode_off: assert property ($past(tuning_mode_select == 4'h0 && !rst) |-> $stable(position_gain_set1))
    else $error("gain changed with tuning off");
  a_row_whole: assert property ($changed(position_gain_set1) |-> $changed(speed_gain_set1))
    else $error("partial row update");
  a_sets_match: assert property (position_gain_set1 == position_gain_set2 && speed_gain_set1 == speed_gain_set2)
    else $error("gain sets differ");
  a_ff_forced: assert property (clk_en && two_dof_mode && tuning_mode_select != 4'h0 |=> effective_ff_gain == 16'h0000)
    else $error("feed-forward not forced off");
  a_estimate_taken: assert property ($past(estimate_valid && clk_en && tuning_mode_select != 4'h0 && !restore_valid && !rst) |-> inertia_ratio == $past(estimate.inertia))
    else $error("estimate not taken");
  a_restore_load: assert property ($past(restore_valid && clk_en && !rst) |-> inertia_ratio == $past(restored.inertia))
    else $error("restore not taken");
  a_write_pulse: assert property (nvm_write |=> !nvm_write)
    else $error("nvm write longer than one cycle");
endmodule : gain_sched_chk
bind realtime_autotune_gain_scheduler gain_sched_chk #(.SAVE_CYCLES(SAVE_CYCLES)) chk_u (.ref_clk,
  .rst, .clk_en, .tuning_mode_select, .two_dof_mode, .motor_moving_pin, .estimate_valid, .estimate,
  .restored, .restore_valid, .position_gain_set1, .position_gain_set2, .speed_gain_set1,
  .speed_gain_set2, .inertia_ratio, .effective_ff_gain, .nvm_write);

// *** verification/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  input wire logic ref_clk,
  input wire logic nvm_write,
  output logic motor_moving_pin,
  output logic operation_start,
  output logic nvm_ready
);
  int slow = 0;
  int left = 0;
  initial begin
    motor_moving_pin = 1'b0;
    operation_start = 1'b0;
    nvm_ready = 1'b1;
  end
  // memory answers promptly or after slow cycles
  always @(posedge ref_clk) begin
    if (nvm_write) begin
      nvm_ready <= (slow == 0);
      left <= slow;
    end else if (left > 0) begin
      left <= left - 1;
      nvm_ready <= (left == 1);
    end
  end
  task automatic move(input int n);
    repeat (4) @(posedge ref_clk); // settle time, scaled down
    #1 operation_start = 1'b1;
    motor_moving_pin = 1'b1;
    @(posedge ref_clk);
    #1 operation_start = 1'b0;
    repeat (n) @(posedge ref_clk);
    #1 motor_moving_pin = 1'b0; // stop before the next command
  endtask : move
endmodule : host_model

// *** verification/tb_realtime_autotune_gain_scheduler.sv ***
`timescale 1ns/1ps
module tb_realtime_autotune_gain_scheduler;
  logic ref_clk, rst, two_dof_mode, motor_moving_pin, operation_start, estimate_valid;
  logic restore_valid, nvm_ready, stiffness_pending, nvm_write;
  logic clk_en = 1'b1;
  logic [3:0] tuning_mode_select;
  logic [4:0] stiffness_setting, applied_stiffness;
  logic [15:0] torque_feedforward_gain, effective_ff_gain, inertia_ratio, torque_addition_value;
  logic [15:0] position_gain_set1, position_gain_set2, speed_gain_set1, speed_gain_set2;
  logic [15:0] integral_time_set1, integral_time_set2, torque_filter_set1, torque_filter_set2;
  logic [15:0] command_smoothing_time, tuning_filter_time, load_fluctuation_filter;
  logic [15:0] pos_direction_compensation, neg_direction_compensation, viscous_friction_gain;
  gain_sched_pkg::tune_result_t estimate, restored, nvm_data;
  int fail_count = 0;
  int checked = 0;
  logic [15:0] rows [2][8] = '{'{16'h0014, 16'h000F, 16'h0E74, 16'h05DC, 16'h077F, 16'h02FC,
    16'h009B, 16'h09C4}, '{16'h0438, 16'h0258, 16'h006E, 16'h0026, 16'h0029, 16'h0011,
    16'h0006, 16'h010E}};
  realtime_autotune_gain_scheduler #(.SAVE_CYCLES(100)) dut_u (.*);
  host_model host_u (.ref_clk, .nvm_write, .motor_moving_pin, .operation_start, .nvm_ready);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic check_row(input int i, input logic hi);
    chk(position_gain_set1, rows[i][0]);
    chk(speed_gain_set1, rows[i][1]);
    chk(integral_time_set1, rows[i][2]);
    chk(torque_filter_set1, rows[i][3]);
    chk(command_smoothing_time, hi ? rows[i][5] : rows[i][4]);
    chk(tuning_filter_time, rows[i][6]);
    chk(load_fluctuation_filter, rows[i][7]);
  endtask : check_row
  task automatic pulse(input logic from_nvm);
    estimate_valid = 1'b1;
    restore_valid = from_nvm;
    step(1);
    estimate_valid = 1'b0;
    restore_valid = 1'b0;
    step(2);
  endtask : pulse
  task automatic test_rows();
    tuning_mode_select = 4'h1;
    step(6);
    check_row(0, 1'b0);
    tuning_mode_select = 4'h2;
    stiffness_setting = 5'h1F;
    step(6);
    check_row(1, 1'b1);
    chk(applied_stiffness, 5'h11);
  endtask : test_rows
  task automatic test_defer();
    tuning_mode_select = 4'h1;
    fork
      host_u.move(20);
      begin
        step(9);
        stiffness_setting = 5'h00;
        step(10);
        chk(position_gain_set1, rows[1][0]);
        chk(stiffness_pending, 1'b1);
      end
    join
    step(6);
    check_row(0, 1'b0);
  endtask : test_defer
  task automatic test_estimate();
    estimate = 80'h1111_2222_3333_4444_5555;
    restored = 80'hAAAA_BBBB_CCCC_DDDD_EEEE;
    tuning_mode_select = 4'h0;
    pulse(1'b0);
    chk(inertia_ratio, 16'h0000);
    tuning_mode_select = 4'h1;
    pulse(1'b0);
    chk(inertia_ratio, 16'h1111);
    chk(torque_addition_value, 16'h0000);
    tuning_mode_select = 4'h5;
    pulse(1'b0);
    chk({inertia_ratio, torque_addition_value, pos_direction_compensation,
      neg_direction_compensation, viscous_friction_gain}, estimate);
    pulse(1'b1);
    chk(inertia_ratio, 16'hAAAA);
    chk(viscous_friction_gain, 16'hEEEE);
  endtask : test_estimate
  task automatic test_ff();
    two_dof_mode = 1'b1;
    step(2);
    chk(effective_ff_gain, 16'h0000);
    tuning_mode_select = 4'h0;
    two_dof_mode = 1'b0;
    torque_feedforward_gain = 16'h0200;
    step(3);
    chk(effective_ff_gain, 16'h0000);
    host_u.move(2);
    step(2);
    chk(effective_ff_gain, 16'h0200);
  endtask : test_ff
  task automatic test_save();
    tuning_mode_select = 4'h5;
    host_u.slow = 6;
    for (int n = 0; n < 300 && nvm_write !== 1'b1; n++) step(1);
    chk(nvm_write, 1'b1);
    chk(nvm_data, restored);
  endtask : test_save
  task automatic test_power_cycle();
    gain_sched_pkg::tune_result_t saved;
    saved = nvm_data; // host keeps the saved copy before power-down
    rst = 1'b1;
    step(2);
    chk(inertia_ratio, 16'h0000);
    chk(stiffness_pending, 1'b1);
    rst = 1'b0;
    restored = saved;
    pulse(1'b1);
    chk(inertia_ratio, 16'hAAAA);
    chk(viscous_friction_gain, 16'hEEEE);
    check_row(0, 1'b0);
    tuning_mode_select = 4'h0;
    restored = 80'h0064_0000_0000_0000_0000;
    pulse(1'b1);
    chk({inertia_ratio, torque_addition_value, pos_direction_compensation,
      neg_direction_compensation, viscous_friction_gain}, restored);
    tuning_mode_select = 4'h5;
    clk_en = 1'b0;
    pulse(1'b0);
    chk(inertia_ratio, 16'h0064);
    clk_en = 1'b1;
    pulse(1'b0);
    chk(inertia_ratio, 16'h1111);
  endtask : test_power_cycle
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    rst = 1'b1;
    tuning_mode_select = 4'h0;
    stiffness_setting = 5'h00;
    two_dof_mode = 1'b0;
    estimate_valid = 1'b0;
    restore_valid = 1'b0;
    estimate = '0;
    restored = '0;
    torque_feedforward_gain = 16'h03E8;
    step(5);
    rst = 1'b0;
    test_rows();
    test_defer();
    test_estimate();
    test_ff();
    test_save();
    test_power_cycle();
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    fail_count++;
    end_of_test();
  end
endmodule : tb_realtime_autotune_gain_scheduler
